// ### verilog/bdmc_buck_dvs_mode_control.sv
// Behaviour
// [RULE1] In run state the run voltage code is the target.
// [RULE2] Host writes of the run code are reached by ramping, never jumping.
// [RULE3] Slew bit 0 steps every 2.0 us, bit 1 every 4.0 us.
// [RULE4] With scaling enabled, standby ramps to the standby code.
// [RULE5] With scaling enabled, sleep ramps to the sleep code, up or down.
// [RULE6] Falling ramps force PWM when the bit is set and fuse is 0.
// [RULE7] Fuse selects tracking reference or fixed soft-start reference.
// [RULE8] Conduction mode is automatic unless forced by bits or state.
// [RULE9] All switching modes exist for either fuse value.
// [RULE10] Enable 0 turns the regulator off and applies discharge.
// [RULE11] Default enabled mode is automatic with light-load pulse skipping.
// [RULE12] Forced PWM keeps PWM at all loads, no pulse skipping.
// [RULE13] Low-bias mode only in standby or sleep with low-bias bit set.
// [RULE14] Run: forced PWM bit picks PWM, else automatic; low-bias ignored.
// [RULE15] Standby: off without standby enable, else PWM, low-bias or automatic.
// [RULE16] Sleep: off without sleep enable, else decoded as in standby.
// [RULE17] Each FET is cut for the rest of the cycle on its limit.
// [RULE18] Sense bits follow the live current-limit conditions.
// [RULE19] Status bit sets after the fault persists beyond 8.0 ms.
// [RULE20] At startup the fused code loads run, standby and sleep codes.
// [RULE21] Host never writes the codes when the fuse is 1.
// [RULE22] Reference moves one step per interval from the current code.
// [RULE23] Debounce restarts on clearing; status stays until software clears.
//
// Control core for one buck regulator: target selection, slewed reference,
// mode decode and current-limit reporting.
// Assumes the analogue stage and host bits; limit inputs are asynchronous.
`timescale 1ns/10ps
module bdmc_buck_dvs_mode_control #(
    parameter int DEBOUNCE_CYCLES = bdmc_pkg::DEBOUNCE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_startup_load,
    input wire logic [5:0] i_fused_voltage_code,
    input wire logic i_scaling_select_fuse,
    input wire logic i_code_write,
    input wire logic [1:0] i_code_write_sel,
    input wire logic [5:0] i_code_write_data,
    input wire bdmc_pkg::bdmc_ctrl_t i_ctrl,
    input wire bdmc_pkg::bdmc_pmic_state_t i_pmic_state,
    input wire logic i_high_side_limit,
    input wire logic i_low_side_limit,
    input wire logic i_cycle_start,
    input wire logic i_status_clear,
    output logic [5:0] o_run_voltage_code,
    output logic [5:0] o_standby_voltage_code,
    output logic [5:0] o_sleep_voltage_code,
    output logic [5:0] o_reference_code,
    output logic o_ramping,
    output bdmc_pkg::bdmc_mode_t o_mode,
    output bdmc_pkg::bdmc_stage_t o_stage,
    output logic o_high_side_gate_cut,
    output logic o_low_side_gate_cut,
    output logic o_high_side_sense,
    output logic o_low_side_sense,
    output logic o_limit_status
);
    initial
    begin
        if (DEBOUNCE_CYCLES < 2)
        begin
            $error("DEBOUNCE_CYCLES must be at least 2");
        end
        if (bdmc_pkg::SLEW_FAST_CYC < 2 || bdmc_pkg::SLEW_SLOW_CYC < bdmc_pkg::SLEW_FAST_CYC)
        begin
            $error("slew intervals must be at least 2 cycles and ordered");
        end
        if (bdmc_pkg::CODE_W != 6)
        begin
            $error("voltage code ports are six bits wide");
        end
    end

    localparam logic [1:0] SEL_RUN = 2'h0;
    localparam logic [1:0] SEL_STBY = 2'h1;
    localparam logic [1:0] SEL_SLEEP = 2'h2;
    localparam int SLEW_W = $clog2(bdmc_pkg::SLEW_SLOW_CYC + 1);
    localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [SLEW_W-1:0] SLEW_FAST = SLEW_W'(bdmc_pkg::SLEW_FAST_CYC - 1);
    localparam logic [SLEW_W-1:0] SLEW_SLOW = SLEW_W'(bdmc_pkg::SLEW_SLOW_CYC - 1);
    localparam logic [DEB_W-1:0] DEB_LIMIT = DEB_W'(DEBOUNCE_CYCLES);

    // Three-stage synchronisers; a change counts once stages two and three agree.
    logic [2:0] hs_sync;
    logic [2:0] ls_sync;
    logic hs_live;
    logic ls_live;

    function automatic logic settle(input logic [2:0] sync, input logic held);
        logic agree;
        agree = sync[1] == sync[2];
        return agree ? sync[2] : held;
    endfunction

    wire next_hs_live = settle(hs_sync, hs_live);
    wire next_ls_live = settle(ls_sync, ls_live);

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            hs_sync <= 3'h0;
            ls_sync <= 3'h0;
            hs_live <= 1'b0;
            ls_live <= 1'b0;
        end
        else
        begin
            hs_sync <= {hs_sync[1:0], i_high_side_limit};
            ls_sync <= {ls_sync[1:0], i_low_side_limit};
            hs_live <= next_hs_live;
            ls_live <= next_ls_live;
        end
    end

    // Voltage code fields, loaded from the fuse image at startup.
    logic [5:0] run_code;
    logic [5:0] stby_code;
    logic [5:0] slp_code;
    // Writes are dropped while the fuse fixes the codes, protecting the fixed table.
    wire wr_ok = i_code_write && !i_scaling_select_fuse; // RULE21

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            run_code <= bdmc_pkg::CODE_RESET;
            stby_code <= bdmc_pkg::CODE_RESET;
            slp_code <= bdmc_pkg::CODE_RESET;
        end
        else if (i_startup_load)
        begin
            run_code <= i_fused_voltage_code; // RULE20
            stby_code <= i_fused_voltage_code; // RULE20
            slp_code <= i_fused_voltage_code; // RULE20
        end
        else if (wr_ok)
        begin
            if (i_code_write_sel == SEL_RUN)
            begin
                run_code <= i_code_write_data;
            end
            if (i_code_write_sel == SEL_STBY)
            begin
                stby_code <= i_code_write_data;
            end
            if (i_code_write_sel == SEL_SLEEP)
            begin
                slp_code <= i_code_write_data;
            end
        end
    end

    // Target selection by PMIC state. Without scaling, the run code holds in
    // every state because no ramp is allowed to follow state events.
    function automatic logic [5:0] target_for(
        input bdmc_pkg::bdmc_pmic_state_t state,
        input logic scaling,
        input logic [5:0] run,
        input logic [5:0] stby,
        input logic [5:0] slp
    );
        logic [5:0] code;
        code = run; // RULE1
        if (scaling)
        begin
            unique case (state)
                bdmc_pkg::BDMC_PMIC_STANDBY:
                begin
                    code = stby; // RULE4
                end
                bdmc_pkg::BDMC_PMIC_SLEEP:
                begin
                    code = slp; // RULE5
                end
                default:
                begin
                    code = run;
                end
            endcase
        end
        return code;
    endfunction

    wire scaling_on = !i_scaling_select_fuse;
    wire [5:0] target_code = target_for(i_pmic_state, scaling_on, run_code, stby_code, slp_code);

    // Slew engine: one code step per interval, starting from wherever the
    // reference currently stands so a retarget never jumps.
    logic [5:0] ref_code;
    logic [SLEW_W-1:0] slew_cnt;
    wire at_target = ref_code == target_code;
    wire rising = target_code > ref_code;
    wire [SLEW_W-1:0] slew_reload = i_ctrl.slew_speed_bit ? SLEW_SLOW : SLEW_FAST; // RULE3
    wire slew_tick = slew_cnt == '0;
    wire [5:0] next_ref_code = at_target || !slew_tick ? ref_code :
        rising ? ref_code + 6'h01 : ref_code - 6'h01; // RULE22
    wire [SLEW_W-1:0] next_slew_cnt = at_target || slew_tick ? slew_reload :
        slew_cnt - SLEW_W'(1); // RULE2

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ref_code <= bdmc_pkg::CODE_RESET;
            slew_cnt <= SLEW_FAST;
        end
        else if (i_startup_load)
        begin
            ref_code <= i_fused_voltage_code;
            slew_cnt <= slew_reload;
        end
        else
        begin
            ref_code <= next_ref_code;
            slew_cnt <= next_slew_cnt;
        end
    end

    // Mode decode by PMIC state and control bits.
    // The fuse is not an input to this decode, so every mode exists for both values.
    // An unused state code turns the regulator off rather than guessing a mode.
    function automatic bdmc_pkg::bdmc_mode_t decode_mode(
        input bdmc_pkg::bdmc_ctrl_t ctrl,
        input bdmc_pkg::bdmc_pmic_state_t state
    );
        logic allowed;
        logic low;
        bdmc_pkg::bdmc_mode_t mode;
        allowed = 1'b0;
        low = 1'b0;
        unique case (state)
            bdmc_pkg::BDMC_PMIC_RUN:
            begin
                allowed = 1'b1;
            end
            bdmc_pkg::BDMC_PMIC_STANDBY:
            begin
                allowed = ctrl.standby_enable; // RULE15
                low = 1'b1;
            end
            bdmc_pkg::BDMC_PMIC_SLEEP:
            begin
                allowed = ctrl.sleep_mode_enable; // RULE16
                low = 1'b1;
            end
            default:
            begin
                allowed = 1'b0;
            end
        endcase
        if (!ctrl.regulator_enable || !allowed)
        begin
            mode = bdmc_pkg::BDMC_MODE_OFF; // RULE10 RULE9
        end
        else if (ctrl.forced_pwm_select)
        begin
            mode = bdmc_pkg::BDMC_MODE_FPWM; // RULE14 RULE8
        end
        else if (low && ctrl.low_bias_select)
        begin
            mode = bdmc_pkg::BDMC_MODE_LOWBIAS; // RULE13
        end
        else
        begin
            mode = bdmc_pkg::BDMC_MODE_AUTO; // RULE11
        end
        return mode;
    endfunction

    wire bdmc_pkg::bdmc_mode_t next_mode = decode_mode(i_ctrl, i_pmic_state);
    wire falling_ramp = !at_target && !rising;
    wire fpwm_ramp = falling_ramp && i_ctrl.forced_pwm_during_falling_ramp &&
        scaling_on; // RULE6
    wire is_on = next_mode != bdmc_pkg::BDMC_MODE_OFF;
    wire force_pwm = next_mode == bdmc_pkg::BDMC_MODE_FPWM || (is_on && fpwm_ramp); // RULE12
    wire bdmc_pkg::bdmc_stage_t next_stage = '{
        regulator_on: is_on,
        discharge_on: !is_on, // RULE10
        forced_pwm: force_pwm,
        pulse_skip_allowed: is_on && !force_pwm, // RULE11
        low_bias: next_mode == bdmc_pkg::BDMC_MODE_LOWBIAS && !force_pwm, // RULE13
        tracking_ref: scaling_on // RULE7
    };

    // Cycle-by-cycle limit: a hit cuts that FET until the next cycle begins.
    logic hs_cut;
    logic ls_cut;
    function automatic logic cut_hold(input logic live, input logic cut, input logic start);
        return live || (cut && !start);
    endfunction

    wire next_hs_cut = cut_hold(next_hs_live, hs_cut, i_cycle_start); // RULE17
    wire next_ls_cut = cut_hold(next_ls_live, ls_cut, i_cycle_start); // RULE17

    // Debounce: counts while either limit is live, restarts when both clear.
    logic [DEB_W-1:0] deb_cnt;
    logic status;
    wire any_live = hs_live || ls_live;
    wire deb_done = deb_cnt == DEB_LIMIT;
    wire [DEB_W-1:0] next_deb_cnt = !any_live ? '0 : // RULE23
        deb_done ? deb_cnt : deb_cnt + DEB_W'(1);
    // Setting wins over a same-cycle software clear.
    wire next_status = (any_live && deb_done) || (status && !i_status_clear); // RULE19 RULE23

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            hs_cut <= 1'b0;
            ls_cut <= 1'b0;
            deb_cnt <= '0;
            status <= 1'b0;
        end
        else
        begin
            hs_cut <= next_hs_cut;
            ls_cut <= next_ls_cut;
            deb_cnt <= next_deb_cnt;
            status <= next_status;
        end
    end

    // Registered outputs.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_run_voltage_code <= bdmc_pkg::CODE_RESET;
            o_standby_voltage_code <= bdmc_pkg::CODE_RESET;
            o_sleep_voltage_code <= bdmc_pkg::CODE_RESET;
            o_reference_code <= bdmc_pkg::CODE_RESET;
            o_ramping <= 1'b0;
            o_mode <= bdmc_pkg::BDMC_MODE_OFF;
            o_stage <= '{discharge_on: 1'b1, default: 1'b0};
            o_high_side_gate_cut <= 1'b0;
            o_low_side_gate_cut <= 1'b0;
            o_high_side_sense <= 1'b0;
            o_low_side_sense <= 1'b0;
            o_limit_status <= 1'b0;
        end
        else
        begin
            o_run_voltage_code <= run_code;
            o_standby_voltage_code <= stby_code;
            o_sleep_voltage_code <= slp_code;
            o_reference_code <= ref_code;
            o_ramping <= !at_target;
            o_mode <= next_mode;
            o_stage <= next_stage;
            o_high_side_gate_cut <= next_hs_cut;
            o_low_side_gate_cut <= next_ls_cut;
            o_high_side_sense <= next_hs_live; // RULE18
            o_low_side_sense <= next_ls_live; // RULE18
            o_limit_status <= next_status;
        end
    end
endmodule

// ### verilog/bdmc_pkg.sv
// Package for the buck scaling and mode control block.
// Assumes a 250 MHz core clock; all users reference names with bdmc_pkg:: scope.
package bdmc_pkg;
    localparam int CODE_W = 6;
    localparam int CLK_MHZ = 250;
    localparam int SLEW_FAST_NS = 2000;
    localparam int SLEW_SLOW_NS = 4000;
    localparam int SLEW_FAST_CYC = (SLEW_FAST_NS * CLK_MHZ) / 1000;
    localparam int SLEW_SLOW_CYC = (SLEW_SLOW_NS * CLK_MHZ) / 1000;
    localparam int DEBOUNCE_US = 8000;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam logic [5:0] CODE_RESET = 6'h00;

    typedef enum logic [1:0] {
        BDMC_PMIC_RUN,
        BDMC_PMIC_STANDBY,
        BDMC_PMIC_SLEEP
    } bdmc_pmic_state_t;

    typedef enum logic [1:0] {
        BDMC_MODE_OFF,
        BDMC_MODE_AUTO,
        BDMC_MODE_FPWM,
        BDMC_MODE_LOWBIAS
    } bdmc_mode_t;

    typedef struct packed {
        logic regulator_enable;
        logic standby_enable;
        logic sleep_mode_enable;
        logic low_bias_select;
        logic forced_pwm_select;
        logic forced_pwm_during_falling_ramp;
        logic slew_speed_bit;
    } bdmc_ctrl_t;

    typedef struct packed {
        logic regulator_on;
        logic discharge_on;
        logic forced_pwm;
        logic pulse_skip_allowed;
        logic low_bias;
        logic tracking_ref;
    } bdmc_stage_t;
endpackage

// ### tb/bdmc_properties.sv
// Concurrent checks for the buck scaling and mode control core.
// Bound to every instance of the core; sees only its ports.
`timescale 1ns/10ps
module bdmc_checker #(
    parameter int DEBOUNCE_CYCLES = 20
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_startup_load,
    input wire logic i_scaling_select_fuse,
    input wire logic i_code_write,
    input wire logic [1:0] i_code_write_sel,
    input wire logic [5:0] i_code_write_data,
    input wire bdmc_pkg::bdmc_ctrl_t i_ctrl,
    input wire bdmc_pkg::bdmc_pmic_state_t i_pmic_state,
    input wire logic i_high_side_limit,
    input wire logic [5:0] o_run_voltage_code,
    input wire logic [5:0] o_reference_code,
    input wire bdmc_pkg::bdmc_mode_t o_mode,
    input wire bdmc_pkg::bdmc_stage_t o_stage,
    input wire logic o_high_side_sense,
    input wire logic o_low_side_sense,
    input wire logic o_limit_status
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Length of the current unbroken run of either sense flag.
    int run_len;
    logic en;
    logic live;
    assign en = i_ctrl.regulator_enable;
    assign live = o_high_side_sense || o_low_side_sense;
    always_ff @(posedge i_clk)
    begin
        run_len <= (!i_rst_n || !live) ? 0 : run_len + 1;
    end
    property p_off;
        !en |=> o_mode == bdmc_pkg::BDMC_MODE_OFF && o_stage.discharge_on;
    endproperty
    a_off: assert property (p_off) else $error("mode not off with enable low");
    property p_run;
        en && i_pmic_state == bdmc_pkg::BDMC_PMIC_RUN
            |=> o_mode == ($past(i_ctrl.forced_pwm_select)
            ? bdmc_pkg::BDMC_MODE_FPWM : bdmc_pkg::BDMC_MODE_AUTO);
    endproperty
    a_run: assert property (p_run) else $error("wrong run mode");
    property p_stby_off;
        en && i_pmic_state == bdmc_pkg::BDMC_PMIC_STANDBY && !i_ctrl.standby_enable
            |=> o_mode == bdmc_pkg::BDMC_MODE_OFF;
    endproperty
    a_stby_off: assert property (p_stby_off) else $error("standby not off");
    property p_low_bias;
        o_mode == bdmc_pkg::BDMC_MODE_LOWBIAS
            |-> $past(i_pmic_state) != bdmc_pkg::BDMC_PMIC_RUN && $past(i_ctrl.low_bias_select);
    endproperty
    a_low_bias: assert property (p_low_bias) else $error("low bias mode not allowed");
    property p_step;
        $changed(o_reference_code) && !$past(i_startup_load) && !$past(i_startup_load, 2)
            |-> o_reference_code == $past(o_reference_code) + 6'h01
            || o_reference_code == $past(o_reference_code) - 6'h01;
    endproperty
    a_step: assert property (p_step) else $error("reference jumped");
    property p_write;
        i_code_write && i_code_write_sel == 2'h0 && !i_scaling_select_fuse && !i_startup_load
            |-> ##2 o_run_voltage_code == $past(i_code_write_data, 2);
    endproperty
    a_write: assert property (p_write) else $error("run code not stored");
    property p_sense;
        i_high_side_limit [*6] |-> o_high_side_sense;
    endproperty
    a_sense: assert property (p_sense) else $error("sense not following limit");
    property p_deb;
        $rose(o_limit_status) |-> run_len >= DEBOUNCE_CYCLES - 1;
    endproperty
    a_deb: assert property (p_deb) else $error("status set too early");
    property p_deb_set;
        run_len == DEBOUNCE_CYCLES + 3 |-> o_limit_status;
    endproperty
    a_deb_set: assert property (p_deb_set) else $error("status not set");
    c_low_bias: cover property (o_mode == bdmc_pkg::BDMC_MODE_LOWBIAS);
    c_step: cover property ($changed(o_reference_code));
    c_status: cover property ($rose(o_limit_status));
endmodule
bind bdmc_buck_dvs_mode_control bdmc_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (
    .i_clk, .i_rst_n, .i_startup_load, .i_scaling_select_fuse, .i_code_write,
    .i_code_write_sel, .i_code_write_data, .i_ctrl, .i_pmic_state, .i_high_side_limit,
    .o_run_voltage_code, .o_reference_code, .o_mode, .o_stage, .o_high_side_sense,
    .o_low_side_sense, .o_limit_status);

// ### tb/bdmc_host_model.sv
// Host model writing voltage codes through the one-cycle strobe port.
// Assumes the bench calls write_code; signals change at falling edges.
`timescale 1ns/10ps
module bdmc_host_model (
    input wire logic i_clk,
    input wire logic i_scaling_select_fuse,
    output logic o_code_write,
    output logic [1:0] o_code_write_sel,
    output logic [5:0] o_code_write_data
);
    initial
    begin
        o_code_write = 1'b0;
        o_code_write_sel = 2'h3;
        o_code_write_data = 6'h00;
    end
    // A careful host leaves the codes alone once the fuse is blown; misuse is opt-in.
    task automatic write_code(input logic [1:0] sel, input logic [5:0] data, input bit misuse);
        if (i_scaling_select_fuse && !misuse)
        begin
            return;
        end
        @(negedge i_clk);
        o_code_write = 1'b1;
        o_code_write_sel = sel;
        o_code_write_data = data;
        @(negedge i_clk);
        o_code_write = 1'b0;
        o_code_write_sel = 2'h3;
        o_code_write_data = ~data;
    endtask
endmodule

// ### tb/test_buck_dvs_mode_control.sv
// Self-checking bench for the buck scaling and mode control core.
// Inputs change at falling edges; the host model writes the codes.
`timescale 1ns/10ps
module test_buck_dvs_mode_control;
    localparam int DEB = 20;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_startup_load = 1'b0;
    logic i_scaling_select_fuse = 1'b0;
    logic i_high_side_limit = 1'b0;
    logic i_low_side_limit = 1'b0;
    logic i_cycle_start = 1'b0;
    logic i_status_clear = 1'b0;
    bdmc_pkg::bdmc_ctrl_t i_ctrl = 7'h00;
    bdmc_pkg::bdmc_pmic_state_t i_pmic_state = bdmc_pkg::BDMC_PMIC_RUN;
    logic i_code_write;
    logic [1:0] i_code_write_sel;
    logic [5:0] i_code_write_data, o_run_voltage_code, o_standby_voltage_code;
    logic [5:0] o_sleep_voltage_code, o_reference_code;
    logic o_ramping, o_high_side_gate_cut, o_low_side_gate_cut;
    logic o_high_side_sense, o_low_side_sense, o_limit_status;
    bdmc_pkg::bdmc_mode_t o_mode;
    bdmc_pkg::bdmc_stage_t o_stage;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    always #2 i_clk = ~i_clk;
    bdmc_host_model bdmc_host_model_inst (.i_clk, .i_scaling_select_fuse,
        .o_code_write(i_code_write), .o_code_write_sel(i_code_write_sel),
        .o_code_write_data(i_code_write_data));
    bdmc_buck_dvs_mode_control #(.DEBOUNCE_CYCLES(DEB)) bdmc_buck_dvs_mode_control_inst (
        .i_clk, .i_rst_n, .i_startup_load, .i_fused_voltage_code(6'h20), .i_scaling_select_fuse,
        .i_code_write, .i_code_write_sel, .i_code_write_data, .i_ctrl, .i_pmic_state,
        .i_high_side_limit, .i_low_side_limit, .i_cycle_start, .i_status_clear,
        .o_run_voltage_code, .o_standby_voltage_code, .o_sleep_voltage_code, .o_reference_code,
        .o_ramping, .o_mode, .o_stage, .o_high_side_gate_cut, .o_low_side_gate_cut,
        .o_high_side_sense, .o_low_side_sense, .o_limit_status);
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait for the next reference step; n returns the cycles taken.
    task automatic wait_step();
        logic [5:0] old;
        old = o_reference_code;
        n = 0;
        while (o_reference_code === old && n < 3000)
        begin
            @(negedge i_clk);
            n++;
        end
    endtask
    task automatic t_startup();
        i_startup_load = 1'b1;
        @(negedge i_clk);
        i_startup_load = 1'b0;
        repeat (3) @(negedge i_clk);
        check("run", 6'h20, o_run_voltage_code);
        check("stby", 6'h20, o_standby_voltage_code);
        check("slp", 6'h20, o_sleep_voltage_code);
        check("ref", 6'h20, o_reference_code);
        $display("startup done");
    endtask
    task automatic t_modes();
        bdmc_pkg::bdmc_mode_t e;
        logic off;
        for (int k = 0; k < 192; k++)
        begin
            i_scaling_select_fuse = k >= 96;
            i_pmic_state = bdmc_pkg::bdmc_pmic_state_t'((k / 32) % 3);
            i_ctrl = {k[4:0], 2'h0};
            off = !k[4] || (i_pmic_state == bdmc_pkg::BDMC_PMIC_STANDBY && !k[3])
                || (i_pmic_state == bdmc_pkg::BDMC_PMIC_SLEEP && !k[2]);
            e = off ? bdmc_pkg::BDMC_MODE_OFF : k[0] ? bdmc_pkg::BDMC_MODE_FPWM
                : (k[1] && i_pmic_state != bdmc_pkg::BDMC_PMIC_RUN) ? bdmc_pkg::BDMC_MODE_LOWBIAS
                : bdmc_pkg::BDMC_MODE_AUTO;
            repeat (2) @(negedge i_clk);
            check("mode", e, o_mode);
            check("stage", {!off, off, e == bdmc_pkg::BDMC_MODE_FPWM,
                !off && e != bdmc_pkg::BDMC_MODE_FPWM, e == bdmc_pkg::BDMC_MODE_LOWBIAS,
                !i_scaling_select_fuse}, o_stage);
        end
        $display("modes done");
    endtask
    task automatic t_ramp();
        i_scaling_select_fuse = 1'b0;
        i_pmic_state = bdmc_pkg::BDMC_PMIC_RUN;
        i_ctrl = 7'h40;
        bdmc_host_model_inst.write_code(2'h0, 6'h22, 1'b0);
        wait_step();
        check("step1", 6'h21, o_reference_code);
        check("ramping", 1'b1, o_ramping);
        wait_step();
        check("fast", bdmc_pkg::SLEW_FAST_CYC, n);
        i_ctrl = 7'h41;
        bdmc_host_model_inst.write_code(2'h0, 6'h24, 1'b0);
        wait_step();
        wait_step();
        check("slow", bdmc_pkg::SLEW_SLOW_CYC, n);
        check("step2", 6'h24, o_reference_code);
        $display("ramp done");
    endtask
    task automatic t_sleep();
        bdmc_host_model_inst.write_code(2'h2, 6'h23, 1'b0);
        i_ctrl = 7'h52;
        i_pmic_state = bdmc_pkg::BDMC_PMIC_SLEEP;
        repeat (5) @(negedge i_clk);
        check("fall pwm", 1'b1, o_stage.forced_pwm);
        wait_step();
        check("sleep", 6'h23, o_reference_code);
        i_ctrl = 7'h72;
        i_pmic_state = bdmc_pkg::BDMC_PMIC_STANDBY;
        wait_step();
        check("standby", 6'h22, o_reference_code);
        i_scaling_select_fuse = 1'b1;
        bdmc_host_model_inst.write_code(2'h0, 6'h3f, 1'b1);
        repeat (3) @(negedge i_clk);
        check("refused", 6'h24, o_run_voltage_code);
        $display("sleep done");
    endtask
    task automatic t_limit();
        i_low_side_limit = 1'b1;
        repeat (8) @(negedge i_clk);
        check("sense", 1'b1, o_low_side_sense);
        i_low_side_limit = 1'b0;
        repeat (8) @(negedge i_clk);
        check("short", 1'b0, o_limit_status);
        check("ls cut", 1'b1, o_low_side_gate_cut);
        i_high_side_limit = 1'b1;
        repeat (DEB) @(negedge i_clk);
        check("early", 1'b0, o_limit_status);
        repeat (10) @(negedge i_clk);
        check("status", 1'b1, o_limit_status);
        i_high_side_limit = 1'b0;
        repeat (8) @(negedge i_clk);
        check("cut", 1'b1, o_high_side_gate_cut);
        check("sticky", 1'b1, o_limit_status);
        i_cycle_start = 1'b1;
        i_status_clear = 1'b1;
        @(negedge i_clk);
        i_cycle_start = 1'b0;
        i_status_clear = 1'b0;
        @(negedge i_clk);
        check("cut end", 1'b0, o_high_side_gate_cut);
        check("ls cut end", 1'b0, o_low_side_gate_cut);
        check("cleared", 1'b0, o_limit_status);
        $display("limit done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_startup();
        t_modes();
        t_ramp();
        t_sleep();
        t_limit();
        end_of_test();
    end
endmodule
